// *** rtl/spm_pkg.sv ***
// Shared constants and types for the serial port pin multiplexer
package spm_pkg;

  // ==========================================================================
  // Sizes
  localparam int SPM_PORTS  = 7;
  localparam int SPM_PINS   = 4 * SPM_PORTS;
  localparam int SPM_PDMS   = 3;
  localparam int SPM_CAMS   = 2;
  localparam int SPM_STRAPS = 6;
  localparam int SPM_PDM_W  = 12;

  // ==========================================================================
  // Pin option codes, one per port
  localparam logic [2:0] SPM_OPT_UART4   = 3'h1;
  localparam logic [2:0] SPM_OPT_SPI     = 3'h2;
  localparam logic [2:0] SPM_OPT_SIMGPIO = 3'h3;
  localparam logic [2:0] SPM_OPT_I2CUART = 3'h4;
  localparam logic [2:0] SPM_OPT_SIMI2C  = 3'h5;
  localparam logic [2:0] SPM_OPT_GPIO    = 3'h6;
  localparam logic [2:0] SPM_OPT_RST     = SPM_OPT_GPIO;

  // ==========================================================================
  // Rate-control channel sharing and time-shared I2C
  localparam int         SPM_PAIR_PRI    = 3;
  localparam int         SPM_PAIR_SEC    = 6;
  localparam logic [6:0] SPM_CRYPTO_MASK = 7'h07;
  localparam logic [6:0] SPM_TSHARE_MASK = 7'h48;

  // ==========================================================================
  // Timing: modulator tick at one quarter of the crystal rate
  localparam int         SPM_XO_DIV      = 4;
  localparam logic [1:0] SPM_DIV_LAST    = 2'(SPM_XO_DIV - 1);
  localparam logic [1:0] SPM_STRAP_WAIT  = 2'h3;

  // ==========================================================================
  // Types
  typedef struct packed {
    logic uartTx;
    logic uartRfr;
    logic spiMosi;
    logic spiMosiOe;
    logic spiMiso;
    logic spiMisoOe;
    logic spiCsN;
    logic spiCsOe;
    logic spiClk;
    logic spiClkOe;
    logic simData;
    logic simDataOe;
    logic simClk;
    logic simRstLow;
    logic sdaLow;
    logic sclLow;
  } spm_ctl_t;

  typedef struct packed {
    logic uartRx;
    logic uartCts;
    logic spiMosi;
    logic spiMiso;
    logic spiCsN;
    logic spiClk;
    logic simData;
    logic sda;
    logic scl;
  } spm_rx_t;

  typedef enum logic [2:0] {
    SPM_ST_WAIT = 3'b001,
    SPM_ST_CAPT = 3'b010,
    SPM_ST_DONE = 3'b100
  } spm_strap_t;

endpackage : spm_pkg

// *** rtl/spm_pdm_if.sv ***
// Interface between the pin multiplexer and one pulse density modulator
`timescale 1ns/1ps
interface spm_pdm_if #(
  parameter int W = 12
);
  logic         tick;
  logic [W-1:0] level;
  logic         pdmOut;

  modport drv (output tick, output level, input pdmOut);
  modport mod (input tick, input level, output pdmOut);
endinterface : spm_pdm_if

// *** rtl/spm_pdm.sv ***
// First-order pulse density modulator stepped by a divided clock enable
`timescale 1ns/1ps
module spm_pdm
  import spm_pkg::*;
#(
  parameter int W = SPM_PDM_W
)
(
  input  wire logic clk,
  input  wire logic rst,
  spm_pdm_if.mod    pif
);

  typedef struct packed {
    logic [W-1:0] acc;
    logic         out;
  } spm_pdm_state_t;

  spm_pdm_state_t q;
  spm_pdm_state_t d;

  // ==========================================================================
  // Accumulate level; the carry out is the density bit
  always_comb
  begin
    d = q;
    if (pif.tick)
    begin
      {d.out, d.acc} = {1'b0, q.acc} + {1'b0, pif.level};
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      q <= '0;
    end
    else
    begin
      q <= d;
    end
  end

  assign pif.pdmOut = q.out;

endmodule : spm_pdm

// *** rtl/spm_serial_port_pin_mux.sv ***
// Pin multiplexer for the seven four-pin general serial ports
`timescale 1ns/1ps

// Summary of operation
// - Seven four-pin ports, each for UART, SIM card, SPI or I2C.
// - Option 1: TX bit3 out, RX bit2 in, CTS bit1 in, RFR bit0 out.
// - Option 2: SPI MOSI bit3, MISO bit2, chip select bit1, clock bit0.
// - Option 3: SIM data bit3, SIM clock bit2, SIM reset bit1, GPIO bit0.
// - Option 4: UART TX bit3, RX bit2, I2C data bit1, clock bit0.
// - Option 5: SIM data bit3, SIM clock bit2, I2C data bit1, clock bit0.
// - Option 6: all four pins are plain two-way GPIOs.
// - Each port owns a fixed group of four pads for bits 3 to 0.
// - Second-revision parts may move a port's pin functions, whatever its option, to alternate pads.
// - A shared rate-control channel serves only one client at a time.
// - SPI and mover-fed UART request the data mover; others do not.
// - Ports four and seven may time-share I2C on bits 3/2 and 1/0.
// - PDM outputs are 12-bit modulators stepped at crystal rate over 4.
// - Boot strap pads are captured once, each configuration strap kept only if fuses allow.
// - One strap pad selects boot from internal ROM.
// - One pad disables the watchdog while it is asserted.
// - Camera timer outputs run synchronously or asynchronously.
// - Extra tri-state SPI chip select pad serves ports five to seven.
module spm_serial_port_pin_mux
  import spm_pkg::*;
#(
  parameter bit REV2 = 1'b1
)
(
  input  wire logic                          clk,
  input  wire logic                          rst,
  input  wire logic                          optWrEn,
  input  wire logic [2:0]                    optWrPort,
  input  wire logic [2:0]                    optWrData,
  input  wire logic [SPM_PORTS-1:0]          moverFedUart,
  input  wire logic [SPM_PORTS-1:0]          altEn,
  input  wire logic [SPM_PORTS-1:0]          i2cUpperSel,
  input  wire spm_ctl_t [SPM_PORTS-1:0]      portCtl,
  input  wire logic [SPM_PINS-1:0]           gpioOut,
  input  wire logic [SPM_PINS-1:0]           gpioOe,
  input  wire logic [SPM_PINS-1:0]           padIn,
  input  wire logic [SPM_PINS-1:0]           altPadIn,
  input  wire logic [SPM_PDMS*SPM_PDM_W-1:0] pdmLevel,
  input  wire logic [SPM_CAMS-1:0]           camTimer,
  input  wire logic [SPM_CAMS-1:0]           camAsync,
  input  wire logic                          camSyncTick,
  input  wire logic [2:0]                    spiCsExtN,
  input  wire logic [1:0]                    csOwner,
  input  wire logic [SPM_STRAPS-1:0]         strapPad,
  input  wire logic [SPM_STRAPS-1:0]         fuseAllow,
  input  wire logic                          romBootPad,
  input  wire logic                          watchdogOffPad,
  output logic [SPM_PINS-1:0]                padOut,
  output logic [SPM_PINS-1:0]                padOe,
  output logic [SPM_PINS-1:0]                altPadOut,
  output logic [SPM_PINS-1:0]                altPadOe,
  output logic [SPM_PINS-1:0]                gpioIn,
  output spm_rx_t [SPM_PORTS-1:0]            portRx,
  output logic [3*SPM_PORTS-1:0]             optSel,
  output logic [SPM_PORTS-1:0]               moverGrant,
  output logic                               cfgConflict,
  output logic [SPM_PDMS-1:0]                pdmOut,
  output logic [SPM_CAMS-1:0]                camTimerOut,
  output logic                               csPadOut,
  output logic                               csPadOe,
  output logic [SPM_STRAPS-1:0]              bootConfig,
  output logic                               bootFromRom,
  output logic                               strapValid,
  output logic                               watchdogOff
);

  // ==========================================================================
  // State
  typedef struct packed {
    logic [SPM_PINS-1:0]       padS1;
    logic [SPM_PINS-1:0]       padS2;
    logic [SPM_PINS-1:0]       altS1;
    logic [SPM_PINS-1:0]       altS2;
    logic [SPM_STRAPS+1:0]     pinS1;
    logic [SPM_STRAPS+1:0]     pinS2;
    logic [3*SPM_PORTS-1:0]    opt;
    logic [SPM_PINS-1:0]       padOut;
    logic [SPM_PINS-1:0]       padOe;
    logic [SPM_PINS-1:0]       altOut;
    logic [SPM_PINS-1:0]       altOe;
    logic [SPM_PINS-1:0]       gpioIn;
    spm_rx_t [SPM_PORTS-1:0]   rx;
    logic [SPM_PORTS-1:0]      grant;
    logic                      conflict;
    logic [1:0]                div;
    logic                      tick;
    logic [SPM_PDMS-1:0]       pdm;
    logic [SPM_CAMS-1:0]       cam;
    logic                      csOut;
    logic                      csOe;
    spm_strap_t                st;
    logic [1:0]                settle;
    logic [SPM_STRAPS-1:0]     bootCfg;
    logic                      romBoot;
    logic                      wdogOff;
  } spm_state_t;

  spm_state_t          q;
  spm_state_t          d;
  logic [SPM_PDMS-1:0] pdmRaw;

  // ==========================================================================
  // Pin mapping of one port: returns {out[3:0], oe[3:0]}
  function automatic logic [7:0] spm_port_mux(
    input logic [2:0] opt,
    input spm_ctl_t   c,
    input logic [3:0] go,
    input logic [3:0] ge,
    input logic       upper
  );
    logic [3:0] o;
    logic [3:0] e;
    o = go;
    e = ge;
    case (opt)
      SPM_OPT_UART4:
      begin
        o = {c.uartTx, 1'b0, 1'b0, c.uartRfr};
        e = 4'b1001;
      end
      SPM_OPT_SPI:
      begin
        o = {c.spiMosi, c.spiMiso, c.spiCsN, c.spiClk};
        e = {c.spiMosiOe, c.spiMisoOe, c.spiCsOe, c.spiClkOe};
      end
      SPM_OPT_SIMGPIO:
      begin
        o = {c.simData, c.simClk, c.simRstLow, go[0]};
        e = {c.simDataOe, 1'b1, 1'b1, ge[0]};
      end
      SPM_OPT_I2CUART:
      begin
        // Open-drain I2C: the pin is driven only while pulled low
        if (upper)
        begin
          o = 4'h0;
          e = {c.sdaLow, c.sclLow, 2'b00};
        end
        else
        begin
          o = {c.uartTx, 3'h0};
          e = {1'b1, 1'b0, c.sdaLow, c.sclLow};
        end
      end
      SPM_OPT_SIMI2C:
      begin
        o = {c.simData, c.simClk, 2'b00};
        e = {c.simDataOe, 1'b1, c.sdaLow, c.sclLow};
      end
      default:
      begin
        o = go;
        e = ge;
      end
    endcase
    return {o, e};
  endfunction : spm_port_mux

  // ==========================================================================
  // Receive routing of one port; unused inputs idle high
  function automatic spm_rx_t spm_port_rx(
    input logic [2:0] opt,
    input logic [3:0] p,
    input logic       upper
  );
    spm_rx_t r;
    r = '1;
    case (opt)
      SPM_OPT_UART4:
      begin
        r.uartRx  = p[2];
        r.uartCts = p[1];
      end
      SPM_OPT_SPI:
      begin
        r.spiMosi = p[3];
        r.spiMiso = p[2];
        r.spiCsN  = p[1];
        r.spiClk  = p[0];
      end
      SPM_OPT_SIMGPIO:
      begin
        r.simData = p[3];
      end
      SPM_OPT_I2CUART:
      begin
        r.uartRx = upper ? 1'b1 : p[2];
        r.sda    = upper ? p[3] : p[1];
        r.scl    = upper ? p[2] : p[0];
      end
      SPM_OPT_SIMI2C:
      begin
        r.simData = p[3];
        r.sda     = p[1];
        r.scl     = p[0];
      end
      default:
      begin
        r = '1;
      end
    endcase
    return r;
  endfunction : spm_port_rx

  function automatic logic spm_wants_mover(
    input logic [2:0] opt,
    input logic       fed
  );
    return (opt == SPM_OPT_SPI) || (fed && ((opt == SPM_OPT_UART4) ||
           (opt == SPM_OPT_I2CUART)));
  endfunction : spm_wants_mover

  // ==========================================================================
  // Modulators
  for (genvar g = 0; g < SPM_PDMS; g++)
  begin : g_pdm
    spm_pdm_if #(.W(SPM_PDM_W)) pif ();
    assign pif.tick  = q.tick;
    assign pif.level = pdmLevel[g*SPM_PDM_W +: SPM_PDM_W];
    assign pdmRaw[g] = pif.pdmOut;
    spm_pdm #(.W(SPM_PDM_W)) u_pdm (
      .clk (clk),
      .rst (rst),
      .pif (pif.mod)
    );
  end

  // ==========================================================================
  // Next state
  always_comb
  begin
    logic [7:0]       m;
    logic [2:0]       o;
    logic [3:0]       pins;
    logic             useAlt;
    logic             up;
    logic [SPM_PORTS-1:0] req;
    m      = '0;
    o      = '0;
    pins   = '0;
    useAlt = 1'b0;
    up     = 1'b0;
    req    = '0;
    d      = q;
    // Pads come from outside the clock domain
    d.padS1 = padIn;
    d.padS2 = q.padS1;
    d.altS1 = altPadIn;
    d.altS2 = q.altS1;
    d.pinS1 = {watchdogOffPad, romBootPad, strapPad};
    d.pinS2 = q.pinS1;
    d.gpioIn = q.padS2;
    // Invalid option codes are dropped so a port never floats undefined
    if (optWrEn && (optWrPort < 3'(SPM_PORTS)) &&
        (optWrData >= SPM_OPT_UART4) && (optWrData <= SPM_OPT_GPIO))
    begin
      d.opt[optWrPort*3 +: 3] = optWrData;
    end
    for (int p = 0; p < SPM_PORTS; p++)
    begin
      o      = q.opt[p*3 +: 3];
      useAlt = REV2 && altEn[p];
      up     = SPM_TSHARE_MASK[p] && i2cUpperSel[p];
      m = spm_port_mux(o, portCtl[p], gpioOut[p*4 +: 4],
                       gpioOe[p*4 +: 4], up);
      d.altOut[p*4 +: 4] = useAlt ? m[7:4] : 4'h0;
      d.altOe[p*4 +: 4]  = useAlt ? m[3:0] : 4'h0;
      d.padOut[p*4 +: 4] = useAlt ? gpioOut[p*4 +: 4] : m[7:4];
      d.padOe[p*4 +: 4]  = useAlt ? gpioOe[p*4 +: 4] : m[3:0];
      pins = useAlt ? q.altS2[p*4 +: 4] : q.padS2[p*4 +: 4];
      d.rx[p] = spm_port_rx(o, pins, up);
      req[p] = spm_wants_mover(o, moverFedUart[p]);
    end
    // Ports one to three stay off the mover, reserved for the crypto engine
    d.grant = req & ~SPM_CRYPTO_MASK;
    d.conflict = |(req & SPM_CRYPTO_MASK);
    if (req[SPM_PAIR_PRI] && req[SPM_PAIR_SEC])
    begin
      d.grant[SPM_PAIR_SEC] = 1'b0;
      d.conflict = 1'b1;
    end
    // Crystal over four enable
    d.div  = (q.div == SPM_DIV_LAST) ? 2'h0 : q.div + 2'h1;
    d.tick = (q.div == SPM_DIV_LAST);
    d.pdm  = pdmRaw;
    for (int t = 0; t < SPM_CAMS; t++)
    begin
      if (camAsync[t] || camSyncTick)
      begin
        d.cam[t] = camTimer[t];
      end
    end
    // Shared chip select is released unless its owner runs SPI
    if (csOwner < 2'h3)
    begin
      d.csOut = spiCsExtN[csOwner];
      d.csOe  = (q.opt[(4 + 32'(csOwner))*3 +: 3] == SPM_OPT_SPI);
    end
    else
    begin
      d.csOut = 1'b1;
      d.csOe  = 1'b0;
    end
    d.wdogOff = q.pinS2[SPM_STRAPS+1];
    // Straps settle through the synchroniser, then are caught once
    case (q.st)
      SPM_ST_WAIT:
      begin
        d.settle = q.settle + 2'h1;
        if (q.settle == SPM_STRAP_WAIT)
        begin
          d.st = SPM_ST_CAPT;
        end
      end
      SPM_ST_CAPT:
      begin
        d.bootCfg = q.pinS2[SPM_STRAPS-1:0] & fuseAllow;
        d.romBoot = q.pinS2[SPM_STRAPS];
        d.st      = SPM_ST_DONE;
      end
      SPM_ST_DONE:
      begin
        d.st = SPM_ST_DONE;
      end
      default:
      begin
        d.st = SPM_ST_WAIT;
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      q     <= '0;
      q.opt <= {SPM_PORTS{SPM_OPT_RST}};
      q.st  <= SPM_ST_WAIT;
      q.rx  <= '1;
    end
    else
    begin
      q <= d;
    end
  end

  // ==========================================================================
  // Outputs
  assign padOut      = q.padOut;
  assign padOe       = q.padOe;
  assign altPadOut   = q.altOut;
  assign altPadOe    = q.altOe;
  assign gpioIn      = q.gpioIn;
  assign portRx      = q.rx;
  assign optSel      = q.opt;
  assign moverGrant  = q.grant;
  assign cfgConflict = q.conflict;
  assign pdmOut      = q.pdm;
  assign camTimerOut = q.cam;
  assign csPadOut    = q.csOut;
  assign csPadOe     = q.csOe;
  assign bootConfig  = q.bootCfg;
  assign bootFromRom = q.romBoot;
  assign strapValid  = q.st[2];
  assign watchdogOff = q.wdogOff;

  // ==========================================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_opt_write: assert property (
    optWrEn && optWrPort == 3'h0 && optWrData == SPM_OPT_SPI
    |=> optSel[2:0] == SPM_OPT_SPI ##1 padOe[3:0] == $past(
      {portCtl[0].spiMosiOe, portCtl[0].spiMisoOe,
       portCtl[0].spiCsOe, portCtl[0].spiClkOe}) || altEn[0])
    else $error("option write did not reach port zero pins");

  a_uart_map: assert property (
    optSel[2:0] == SPM_OPT_UART4 && !(REV2 && altEn[0])
    |=> padOe[3:0] == 4'b1001 && padOut[3] == $past(portCtl[0].uartTx))
    else $error("four-pin UART mapping wrong");

  a_sim_map: assert property (
    optSel[5:3] == SPM_OPT_SIMGPIO && !(REV2 && altEn[1])
    |=> padOut[5] == $past(portCtl[1].simRstLow)
        && padOut[4] == $past(gpioOut[4]) && padOe[6:5] == 2'b11)
    else $error("SIM plus GPIO mapping wrong");

  a_gpio_map: assert property (
    optSel[20:18] == SPM_OPT_GPIO && !(REV2 && altEn[6])
    |=> padOe[27:24] == $past(gpioOe[27:24]))
    else $error("GPIO option does not follow enables");

  a_mover_excl: assert property (
    !(moverGrant[SPM_PAIR_PRI] && moverGrant[SPM_PAIR_SEC]))
    else $error("shared channel granted to both clients");

  a_crypto_keep: assert property (
    (moverGrant & SPM_CRYPTO_MASK) == 7'h00)
    else $error("mover granted to a crypto-reserved port");

  a_pdm_rate: assert property (
    q.tick |=> !q.tick [*3] ##1 q.tick)
    else $error("modulator enable not one in four");

  a_wdog_path: assert property (
    (!rst) [*4] |-> watchdogOff == $past(watchdogOffPad, 3))
    else $error("watchdog disable latency wrong");

  a_strap_hold: assert property (
    strapValid && $past(strapValid) |-> $stable(bootConfig)
      && (bootConfig & ~fuseAllow) == '0 || $changed(fuseAllow))
    else $error("strap value changed after capture");

  a_cs_release: assert property (
    csOwner == 2'h3 |=> !csPadOe)
    else $error("shared chip select driven without owner");

endmodule : spm_serial_port_pin_mux

// *** dv/spm_pad_partner.sv ***
// Pad-side partner: external parties sharing the multiplexed pins
`timescale 1ns/1ps
module spm_pad_partner
  import spm_pkg::*;
(
  input  wire logic [SPM_PINS-1:0] padOut,
  input  wire logic [SPM_PINS-1:0] padOe,
  input  wire logic [SPM_PINS-1:0] extLvl,
  output logic      [SPM_PINS-1:0] padIn
);
  // ==========================================================================
  // Wire level
  // A driven pin reads back its own level, so two-way and open-drain pins
  // see what the device puts out; released pins carry the far side's level
  assign padIn = (padOe & padOut) | (~padOe & extLvl);
endmodule : spm_pad_partner

// *** dv/serial_port_pin_mux_tb.sv ***
// Self-checking bench for the serial port pin multiplexer
`timescale 1ns/1ps
module serial_port_pin_mux_tb import spm_pkg::*;;
  localparam int LIMIT = 40000;
  logic                          clk, rst, optWrEn, camSyncTick;
  logic                          romBootPad, watchdogOffPad, cfgConflict;
  logic                          csPadOut, csPadOe, bootFromRom;
  logic                          strapValid, watchdogOff;
  logic [2:0]                    optWrPort, optWrData, spiCsExtN;
  logic [1:0]                    csOwner, camTimer, camAsync, camLast;
  logic [1:0]                    camTimerOut;
  logic [SPM_PORTS-1:0]          moverFedUart, altEn, i2cUpperSel, moverGrant;
  spm_ctl_t [SPM_PORTS-1:0]      portCtl;
  spm_rx_t [SPM_PORTS-1:0]       portRx;
  logic [SPM_PINS-1:0]           gpioOut, gpioOe, padIn, altPadIn, ext;
  logic [SPM_PINS-1:0]           altExt, padOut, padOe, altPadOut, altPadOe;
  logic [SPM_PINS-1:0]           gpioIn;
  logic [SPM_PDMS*SPM_PDM_W-1:0] pdmLevel;
  logic [SPM_STRAPS-1:0]         strapPad, fuseAllow, bootConfig, strapSave;
  logic [3*SPM_PORTS-1:0]        optSel;
  logic [SPM_PDMS-1:0]           pdmOut;
  logic [2:0]                    opt [SPM_PORTS];
  logic [31:0]                   seed = 32'h00008170;
  int                            miscompares = 0, checked = 0, cyc = 0;

  spm_serial_port_pin_mux dut (.clk, .rst, .optWrEn, .optWrPort, .optWrData,
    .moverFedUart, .altEn, .i2cUpperSel, .portCtl, .gpioOut, .gpioOe, .padIn,
    .altPadIn, .pdmLevel, .camTimer, .camAsync, .camSyncTick, .spiCsExtN,
    .csOwner, .strapPad, .fuseAllow, .romBootPad, .watchdogOffPad, .padOut,
    .padOe, .altPadOut, .altPadOe, .gpioIn, .portRx, .optSel, .moverGrant,
    .cfgConflict, .pdmOut, .camTimerOut, .csPadOut, .csPadOe, .bootConfig,
    .bootFromRom, .strapValid, .watchdogOff);
  spm_pad_partner pri (.padOut, .padOe, .extLvl(ext), .padIn);
  spm_pad_partner alt (.padOut(altPadOut), .padOe(altPadOe),
    .extLvl(altExt), .padIn(altPadIn));

  // ==========================================================================
  // Clock and cycle ceiling
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == LIMIT)
    begin
      miscompares++;
      $display("[FAIL] %0t run did not finish in time", $time);
      end_sim();
    end
  end

  // ==========================================================================
  // Expectation helpers
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  // Returns {out, enable}; outputs on input-only pins are left open
  function automatic logic [7:0] muxExp(input logic [2:0] o, input spm_ctl_t c,
    input logic [3:0] go, input logic [3:0] ge, input logic u);
    case (o)
      SPM_OPT_UART4:   return {c.uartTx, 2'b00, c.uartRfr, 4'h9};
      SPM_OPT_SPI:     return {c.spiMosi, c.spiMiso, c.spiCsN, c.spiClk,
                               c.spiMosiOe, c.spiMisoOe, c.spiCsOe, c.spiClkOe};
      SPM_OPT_SIMGPIO: return {c.simData, c.simClk, c.simRstLow, go[0],
                               c.simDataOe, 2'b11, ge[0]};
      SPM_OPT_I2CUART: return u ? {4'h0, c.sdaLow, c.sclLow, 2'b00} :
                               {c.uartTx, 3'h0, 2'b10, c.sdaLow, c.sclLow};
      SPM_OPT_SIMI2C:  return {c.simData, c.simClk, 2'b00,
                               c.simDataOe, 1'b1, c.sdaLow, c.sclLow};
      default:         return {go, ge};
    endcase
  endfunction : muxExp
  function automatic spm_rx_t rxExp(input logic [2:0] o, input logic [3:0] p,
                                    input logic u);
    spm_rx_t r;
    r = '1;
    case (o)
      SPM_OPT_UART4:   {r.uartRx, r.uartCts} = p[2:1];
      SPM_OPT_SPI:     {r.spiMosi, r.spiMiso, r.spiCsN, r.spiClk} = p;
      SPM_OPT_SIMGPIO: r.simData = p[3];
      SPM_OPT_I2CUART: {r.uartRx, r.sda, r.scl} = u ? {1'b1, p[3:2]} : p[2:0];
      SPM_OPT_SIMI2C:  {r.simData, r.sda, r.scl} = {p[3], p[1:0]};
      default:         r = '1;
    endcase
    return r;
  endfunction : rxExp
  // Returns {conflict, grants}; the fourth port wins a shared channel
  function automatic logic [7:0] grantExp();
    logic [6:0] rq, g;
    for (int p = 0; p < SPM_PORTS; p++)
      rq[p] = (opt[p] == SPM_OPT_SPI) || (moverFedUart[p] &&
              (opt[p] == SPM_OPT_UART4 || opt[p] == SPM_OPT_I2CUART));
    g = rq & ~SPM_CRYPTO_MASK;
    if (g[SPM_PAIR_PRI])
      g[SPM_PAIR_SEC] = 1'b0;
    return {(|(rq & SPM_CRYPTO_MASK)) || (rq[3] && rq[6]), g};
  endfunction : grantExp

  // ==========================================================================
  // Tasks
  task automatic cmp(input logic [63:0] got, input logic [63:0] exp,
                     input string what);
    checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[FAIL] %0t %s: got %0h expected %0h", $time, what, got, exp);
    end
  endtask : cmp
  task automatic end_sim();
    $display("comparisons %0d, mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : end_sim
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask : settle
  task automatic chk_all();
    logic [7:0] m;
    logic [3:0] e, o, ae;
    logic       ce, u;
    for (int p = 0; p < SPM_PORTS; p++)
    begin
      u = i2cUpperSel[p] && SPM_TSHARE_MASK[p];
      m = muxExp(opt[p], portCtl[p], gpioOut[4*p+:4], gpioOe[4*p+:4], u);
      e = altEn[p] ? gpioOe[4*p+:4] : m[3:0];
      o = altEn[p] ? gpioOut[4*p+:4] : m[7:4];
      ae = altEn[p] ? m[3:0] : 4'h0;
      cmp(optSel[3*p+:3], opt[p], "option");
      cmp(padOe[4*p+:4], e, "pad enable");
      cmp(padOut[4*p+:4] & e, o & e,
          "pad out");
      cmp(altPadOe[4*p+:4], ae, "alt enable");
      cmp(altPadOut[4*p+:4] & (altEn[p] ? ae : 4'hF), m[7:4] & ae,
          "alt out");
      cmp(portRx[p], rxExp(opt[p], altEn[p] ? altPadIn[4*p+:4]
          : padIn[4*p+:4], u), "rx route");
    end
    ce = (csOwner != 2'h3) && (opt[3'h4 + 3'(csOwner)] == SPM_OPT_SPI);
    cmp(gpioIn, padIn, "gpio in");
    cmp({cfgConflict, moverGrant}, grantExp(),
        "mover");
    cmp(csPadOe, ce, "cs enable");
    if (csOwner != 2'h3)
      cmp(csPadOut, spiCsExtN[csOwner], "cs out");
    cmp(watchdogOff, watchdogOffPad, "watchdog");
  endtask : chk_all
  task automatic wr(input logic [2:0] p, input logic [2:0] d);
    @(posedge clk);
    optWrEn <= 1'b1;
    optWrPort <= p;
    optWrData <= d;
    if (p < 3'h7 && d != 3'h0 && d != 3'h7)
      opt[p] = d;
  endtask : wr
  task automatic stim();
    logic [31:0] r;
    @(posedge clk);
    optWrEn <= 1'b0;
    foreach (portCtl[p])
    begin
      r = rnd();
      portCtl[p] <= spm_ctl_t'(r[15:0]);
    end
    gpioOut <= 28'(rnd());
    gpioOe <= 28'(rnd());
    ext <= 28'(rnd());
    altExt <= 28'(rnd());
    r = rnd();
    altEn <= r[6:0];
    moverFedUart <= r[13:7];
    spiCsExtN <= r[16:14];
    csOwner <= r[18:17];
    watchdogOffPad <= r[19];
    i2cUpperSel <= r[26:20];
    settle(6);
    chk_all();
  endtask : stim
  task automatic do_reset();
    @(posedge clk);
    rst <= 1'b1;
    foreach (opt[p])
      opt[p] = SPM_OPT_RST;
    settle(12);
    cmp(optSel, {SPM_PORTS{SPM_OPT_RST}}, "reset option");
    cmp({padOe, altPadOe, moverGrant}, '0, "reset drive");
    cmp({portRx, strapValid}, {{9*SPM_PORTS{1'b1}}, 1'b0}, "reset rx");
    @(posedge clk);
    rst <= 1'b0;
    $display("test reset done");
  endtask : do_reset

  // ==========================================================================
  // Main sequence
  initial
  begin
    int c[SPM_PDMS];
    int l;
    rst = 1'b1;
    {optWrEn, optWrPort, optWrData, camSyncTick, camAsync} = '0;
    {moverFedUart, altEn, i2cUpperSel, portCtl, gpioOut, gpioOe} = '0;
    {ext, altExt, pdmLevel, spiCsExtN, csOwner, watchdogOffPad} = '0;
    camTimer = 2'h0;
    strapPad = 6'(rnd());
    fuseAllow = 6'(rnd());
    romBootPad = 1'b1;
    strapSave = strapPad;
    do_reset();
    settle(2);
    cmp(strapValid, 1'b0, "strap early");
    settle(5);
    cmp({strapValid, bootFromRom}, 2'b11, "strap done");
    cmp(bootConfig, strapSave & fuseAllow, "straps");
    strapPad <= ~strapPad;
    settle(6);
    cmp(bootConfig, strapSave & fuseAllow, "straps held");
    $display("test straps done");
    wr(3'h7, 3'h2);
    wr(3'h0, 3'h0);
    wr(3'h0, 3'h7);
    stim();
    for (int k = 1; k < 7; k++)
    begin
      foreach (opt[p])
        wr(3'(p), 3'(k));
      stim();
    end
    $display("test every option done");
    repeat (150)
    begin
      repeat (rnd() % 3 + 1)
        wr(3'(rnd()), 3'(rnd()));
      stim();
    end
    $display("test random done");
    for (int i = 1; i < 3; i++)
    begin
      @(posedge clk);
      camAsync <= 2'(i);
      camSyncTick <= 1'b1;
      camTimer <= 2'(rnd());
      @(posedge clk);
      camSyncTick <= 1'b0;
      settle(3);
      camLast = camTimer;
      cmp(camTimerOut, camTimer, "cam tick");
      @(posedge clk);
      camTimer <= ~camTimer;
      settle(3);
      cmp(camTimerOut, (camTimer & camAsync) | (camLast & ~camAsync),
          "cam mode");
    end
    $display("test camera done");
    @(posedge clk);
    pdmLevel <= {12'hFFF, 12'h000, 12'(rnd())};
    c = '{default: 0};
    repeat (8) @(posedge clk);
    repeat (4 * 4096) @(posedge clk)
      foreach (c[g])
        c[g] += int'(pdmOut[g]);
    foreach (c[g])
    begin
      l = int'(pdmLevel[SPM_PDM_W*g+:SPM_PDM_W]);
      cmp((c[g] >= l - 1 && c[g] <= l + 1) || (c[g] >= 4 * l - 4 &&
          c[g] <= 4 * l + 4), 1'b1, "density");
    end
    $display("test modulator done");
    romBootPad <= 1'b0;
    do_reset();
    stim();
    cmp({strapValid, bootFromRom, bootConfig},
        {2'b10, strapPad & fuseAllow}, "strap again");
    end_sim();
  end
endmodule : serial_port_pin_mux_tb
